//--- design/plte_exec.sv
// module: executes reset, assign, load and transfer instructions
`timescale 1ns/1ps
`default_nettype none
module plte_exec
  import plte_pkg::*;
#(
  parameter int IMG_BYTES  = 128,
  parameter int FLAG_BYTES = 256,
  parameter int DB_WORDS   = 256,
  parameter int TC_COUNT   = 64
) (
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               sys_rst_i,
  // instruction stream
  input  wire logic               instr_valid_i,
  input  wire plte_pkg::plte_instr_s instr_i,
  // logic result from the boolean unit
  input  wire logic               logic_result_bit_i,
  // timer/counter value source, binary
  input  wire logic [9:0]         tc_value_i,
  // accumulator, status and byte 0 of the output and interrupt output images
  output logic [15:0]             first_accumulator_o,
  output logic                    reload_mark_o,
  output logic                    done_o,
  output logic [7:0]              out_image_byte0_o,
  output logic [7:0]              irq_out_byte0_o
);
  import plte_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [7:0]  in_img_q   [IMG_BYTES];
  logic [7:0]  out_img_q  [IMG_BYTES];
  logic [7:0]  irq_in_q   [IMG_BYTES];
  logic [7:0]  irq_out_q  [IMG_BYTES];
  logic [7:0]  flag_q     [FLAG_BYTES];
  logic [15:0] db_q       [DB_WORDS];

  logic [15:0] acc_q, acc_d;
  logic        reload_q, reload_d;
  logic        done_q, done_d;

  logic [IMG_AW-1:0]  ia, ia1;
  logic [FLAG_AW-1:0] fa, fa1;
  logic [DB_AW-1:0]   da;
  logic [15:0]        tc_bcd;

  assign ia  = instr_i.byte_addr[IMG_AW-1:0];
  assign ia1 = IMG_AW'(ia + 1'b1);
  assign fa  = instr_i.byte_addr[FLAG_AW-1:0];
  assign fa1 = FLAG_AW'(fa + 1'b1);
  assign da  = instr_i.byte_addr[DB_AW-1:0];

  // binary to bcd for coded timer/counter load
  always_comb begin
    logic [9:0] v;
    v      = (tc_value_i > TC_MAX) ? TC_MAX : tc_value_i;
    tc_bcd = {4'h0, 4'(v / 10'd100), 4'((v / 10'd10) % 10'd10), 4'(v % 10'd10)};
  end

  // ****************************************
  // accumulator and status next state
  // ****************************************
  always_comb begin
    acc_d    = acc_q;
    reload_d = reload_q;
    done_d   = 1'b0;
    if (instr_valid_i) begin
      done_d = 1'b1;
      unique case (instr_i.op)
        OP_RESET,
        OP_ASSIGN: reload_d = 1'b1;
        OP_L_IB:  acc_d = {8'h00, in_img_q[ia]};
        OP_L_QB:  acc_d = {8'h00, out_img_q[ia]};
        OP_L_IW:  acc_d = {in_img_q[ia], in_img_q[ia1]};
        OP_L_QW:  acc_d = {out_img_q[ia], out_img_q[ia1]};
        OP_L_PY:  acc_d = {8'h00, irq_in_q[ia]};
        OP_L_PW:  acc_d = {irq_in_q[ia], irq_in_q[ia1]};
        OP_L_FY:  acc_d = {8'h00, flag_q[fa]};
        OP_L_FW:  acc_d = {flag_q[fa], flag_q[fa1]};
        OP_L_DHB: acc_d = {8'h00, db_q[da][15:8]};
        OP_L_DLB: acc_d = {8'h00, db_q[da][7:0]};
        OP_L_DW:  acc_d = db_q[da];
        OP_L_K1:  acc_d = {8'h00, instr_i.imm[7:0]};
        OP_L_K2:  acc_d = instr_i.imm;
        OP_L_KBCD: acc_d = instr_i.imm;
        OP_L_TC:  acc_d = {6'h00, tc_value_i};
        OP_LC_TC: acc_d = tc_bcd;
        default:  acc_d = acc_q;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_q    <= ACC_RST;
      reload_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      acc_q    <= acc_d;
      reload_q <= reload_d;
      done_q   <= done_d;
    end
  end

  // ****************************************
  // memory writes
  // ****************************************
  logic       bit_wr;
  logic       bit_val;
  logic [7:0] bit_mask;

  always_comb begin
    bit_mask = 8'(8'h01 << instr_i.bit_idx);
    bit_wr   = 1'b0;
    bit_val  = 1'b0;
    if (instr_valid_i && instr_i.op == OP_RESET && logic_result_bit_i) begin
      bit_wr  = 1'b1;
      bit_val = 1'b0;
    end else if (instr_valid_i && instr_i.op == OP_ASSIGN) begin
      bit_wr  = 1'b1;
      bit_val = logic_result_bit_i;
    end
  end

  function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [7:0] m,
                                         input logic v);
    put_bit = v ? (b | m) : (b & ~m);
  endfunction

  logic is_t;
  assign is_t = instr_valid_i;

  // image tables: one generate loop over entries
  for (genvar g = 0; g < IMG_BYTES; g++) begin : g_img
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        in_img_q[g]  <= BYTE_RST;
        out_img_q[g] <= BYTE_RST;
        irq_out_q[g] <= BYTE_RST;
        irq_in_q[g]  <= BYTE_RST;
      end else if (is_t) begin
        if (bit_wr && instr_i.area == AREA_IN && ia == g)
          in_img_q[g] <= put_bit(in_img_q[g], bit_mask, bit_val);
        if (bit_wr && instr_i.area == AREA_OUT && ia == g)
          out_img_q[g] <= put_bit(out_img_q[g], bit_mask, bit_val);
        if (instr_i.op == OP_T_IB && ia == g)
          in_img_q[g] <= acc_q[7:0];
        if ((instr_i.op == OP_T_QB || instr_i.op == OP_T_PY) && ia == g)
          out_img_q[g] <= acc_q[7:0];
        if (instr_i.op == OP_T_PY && ia == g)
          irq_out_q[g] <= acc_q[7:0];
        if (instr_i.op == OP_T_IW && ia == g)
          in_img_q[g] <= acc_q[15:8];
        if (instr_i.op == OP_T_IW && ia1 == g)
          in_img_q[g] <= acc_q[7:0];
        if ((instr_i.op == OP_T_QW || instr_i.op == OP_T_PW) && ia == g)
          out_img_q[g] <= acc_q[15:8];
        if ((instr_i.op == OP_T_QW || instr_i.op == OP_T_PW) && ia1 == g)
          out_img_q[g] <= acc_q[7:0];
        if (instr_i.op == OP_T_PW && ia == g)
          irq_out_q[g] <= acc_q[15:8];
        if (instr_i.op == OP_T_PW && ia1 == g)
          irq_out_q[g] <= acc_q[7:0];
        // interrupt input image refreshed from the input image on every instruction,
        // so a peripheral load sees a settled copy of both bytes of a word
        irq_in_q[g] <= in_img_q[g];
      end
    end
  end

  for (genvar g = 0; g < FLAG_BYTES; g++) begin : g_flag
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        flag_q[g] <= BYTE_RST;
      end else if (is_t) begin
        if (bit_wr && instr_i.area == AREA_FLAG && fa == g)
          flag_q[g] <= put_bit(flag_q[g], bit_mask, bit_val);
        if (instr_i.op == OP_T_FY && fa == g)
          flag_q[g] <= acc_q[7:0];
        if (instr_i.op == OP_T_FW && fa == g)
          flag_q[g] <= acc_q[15:8];
        if (instr_i.op == OP_T_FW && fa1 == g)
          flag_q[g] <= acc_q[7:0];
      end
    end
  end

  for (genvar g = 0; g < DB_WORDS; g++) begin : g_db
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i)
        db_q[g] <= {BYTE_RST, BYTE_RST};
    end
  end

  assign first_accumulator_o = acc_q;
  assign reload_mark_o       = reload_q;
  assign done_o              = done_q;
  assign out_image_byte0_o   = out_img_q[0];
  assign irq_out_byte0_o     = irq_out_q[0];

endmodule
`default_nettype wire

//--- design/plte_pkg.sv
// package: shared constants, opcodes and carriers for the load/transfer executor
package plte_pkg;

  // ****************************************
  // sizes and reset values
  // ****************************************
  localparam int          IMG_AW      = 7;
  localparam int          FLAG_AW     = 8;
  localparam int          DB_AW       = 8;
  localparam int          TC_AW       = 6;
  localparam logic [15:0] ACC_RST     = 16'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [9:0]  TC_MAX      = 10'h3e7;

  // ****************************************
  // opcodes
  // ****************************************
  typedef enum logic [4:0] {
    OP_NOP      = 5'h00,
    OP_RESET    = 5'h01,
    OP_ASSIGN   = 5'h02,
    OP_L_IB     = 5'h03,
    OP_L_QB     = 5'h04,
    OP_L_IW     = 5'h05,
    OP_L_QW     = 5'h06,
    OP_L_PY     = 5'h07,
    OP_L_PW     = 5'h08,
    OP_L_FY     = 5'h09,
    OP_L_FW     = 5'h0a,
    OP_L_DHB    = 5'h0b,
    OP_L_DLB    = 5'h0c,
    OP_L_DW     = 5'h0d,
    OP_L_K1     = 5'h0e,
    OP_L_K2     = 5'h0f,
    OP_L_KBCD   = 5'h10,
    OP_L_TC     = 5'h11,
    OP_LC_TC    = 5'h12,
    OP_T_IB     = 5'h13,
    OP_T_QB     = 5'h14,
    OP_T_IW     = 5'h15,
    OP_T_QW     = 5'h16,
    OP_T_PY     = 5'h17,
    OP_T_PW     = 5'h18,
    OP_T_FY     = 5'h19,
    OP_T_FW     = 5'h1a
  } plte_op_e;

  // bit operand areas for reset and assign
  typedef enum logic [1:0] {
    AREA_IN   = 2'h0,
    AREA_OUT  = 2'h1,
    AREA_FLAG = 2'h2
  } plte_area_e;

  // ****************************************
  // instruction carrier
  // ****************************************
  typedef struct packed {
    plte_op_e   op;
    plte_area_e area;
    logic [7:0] byte_addr;
    logic [2:0] bit_idx;
    logic [15:0] imm;
  } plte_instr_s;

endpackage

//--- tb/plte_exec_sva.sv
// checker: port assertions for the load/transfer executor
`timescale 1ns/1ps
`default_nettype none
module plte_exec_sva
  import plte_pkg::*;
(
  // clock and reset
  input wire logic                  clock_i,
  input wire logic                  sys_rst_i,
  // executor inputs
  input wire logic                  instr_valid_i,
  input wire plte_pkg::plte_instr_s instr_i,
  input wire logic                  logic_result_bit_i,
  input wire logic [9:0]            tc_value_i,
  // executor outputs
  input wire logic [15:0]           first_accumulator_o,
  input wire logic                  reload_mark_o,
  input wire logic                  done_o,
  input wire logic [7:0]            out_image_byte0_o,
  input wire logic [7:0]            irq_out_byte0_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic        go;
  logic [4:0]  op;
  logic [15:0] acc;
  assign go  = instr_valid_i;
  assign op  = instr_i.op;
  assign acc = first_accumulator_o;
  a_done_pulse:
    assert property (go |=> done_o) else $error("done missing");
  a_done_cause:
    assert property (done_o |-> $past(go)) else $error("done without instruction");
  a_const_byte:
    assert property (go && op == OP_L_K1 |=> acc == {8'h00, $past(instr_i.imm[7:0])})
    else $error("one-byte constant wrong");
  a_const_word:
    assert property (go && op == OP_L_K2 |=> acc == $past(instr_i.imm))
    else $error("two-byte constant wrong");
  a_tc_binary:
    assert property (go && op == OP_L_TC |=> acc == {6'h00, $past(tc_value_i)})
    else $error("timer value wrong");
  a_reload_mark:
    assert property (go && (op == OP_RESET || op == OP_ASSIGN) |=> reload_mark_o)
    else $error("reload mark missing");
  a_assign_bit:
    assert property (go && op == OP_ASSIGN && instr_i.area == AREA_OUT
      && instr_i.byte_addr == 8'h00 |=> out_image_byte0_o[$past(instr_i.bit_idx)]
      == $past(logic_result_bit_i)) else $error("assigned bit wrong");
  a_xfer_keeps_acc:
    assert property (go && op >= OP_T_IB |=> $stable(acc)) else $error("transfer moved acc");
  a_byte_zero_fill:
    assert property (go && op inside {OP_L_IB, OP_L_QB, OP_L_PY, OP_L_FY, OP_L_DHB,
      OP_L_DLB, OP_L_K1} |=> acc[15:8] == 8'h00) else $error("high byte not zero");
  a_periph_both:
    assert property (go && op == OP_T_PY && instr_i.byte_addr == 8'h00 |=>
      irq_out_byte0_o == $past(acc[7:0]) && out_image_byte0_o == $past(acc[7:0]))
    else $error("peripheral transfer wrong");
endmodule
bind plte_exec plte_exec_sva u_sva (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .logic_result_bit_i(logic_result_bit_i),
  .tc_value_i(tc_value_i), .first_accumulator_o(first_accumulator_o),
  .reload_mark_o(reload_mark_o), .done_o(done_o), .out_image_byte0_o(out_image_byte0_o),
  .irq_out_byte0_o(irq_out_byte0_o));
`default_nettype wire

//--- tb/plte_tc_model.sv
// partner: timer and counter store seen by the executor
`timescale 1ns/1ps
`default_nettype none
module plte_tc_model
  import plte_pkg::*;
(
  // addressed instruction
  input  wire plte_pkg::plte_instr_s instr_i,
  // binary time or count value
  output logic [9:0]                 tc_value_o
);
  // three times the timer number plus 100, always below 999
  assign tc_value_o = 10'(instr_i.byte_addr[5:0]) * 10'd3 + 10'd100;
endmodule
`default_nettype wire

//--- tb/tb_plc_load_transfer_exec.sv
// testbench: self-checking run of the load/transfer executor
`timescale 1ns/1ps
`default_nettype none
module tb_plc_load_transfer_exec;
  import plte_pkg::*;
  logic        clock_i, sys_rst_i, instr_valid_i, logic_result_bit_i, mark, done;
  plte_instr_s instr_i;
  logic [9:0]  tc_value;
  logic [15:0] acc;
  logic [7:0]  out_b0, irq_b0;
  int          fail_count, check_count, cycles;
  plte_exec DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .logic_result_bit_i(logic_result_bit_i), .tc_value_i(tc_value),
    .first_accumulator_o(acc), .reload_mark_o(mark), .done_o(done),
    .out_image_byte0_o(out_b0), .irq_out_byte0_o(irq_b0));
  plte_tc_model u_tc (.instr_i(instr_i), .tc_value_o(tc_value));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one instruction, then done is looked at in its single cycle
  task automatic run(input plte_op_e op, input logic [7:0] adr, input logic [15:0] imm,
                     input logic [2:0] b = 3'h0, input logic r = 1'b0);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    logic_result_bit_i <= r;
    instr_i <= '{op, AREA_OUT, adr, b, imm};
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    #1;
    chk({15'h0000, done}, 16'h0001);
  endtask
  task automatic t_bits;
    chk({7'h00, mark, out_b0}, 16'h0000);
    run(OP_L_K1, 8'h00, 16'h00ff);
    run(OP_T_QB, 8'h00, 16'h0000);
    chk({8'h00, out_b0}, 16'h00ff);
    run(OP_RESET, 8'h00, 16'h0000, 3'h2, 1'b0);
    chk({7'h00, mark, out_b0}, 16'h01ff);
    run(OP_RESET, 8'h00, 16'h0000, 3'h2, 1'b1);
    chk({8'h00, out_b0}, 16'h00fb);
    run(OP_ASSIGN, 8'h00, 16'h0000, 3'h2, 1'b1);
    chk({8'h00, out_b0}, 16'h00ff);
    run(OP_ASSIGN, 8'h00, 16'h0000, 3'h0, 1'b0);
    chk({8'h00, out_b0}, 16'h00fe);
  endtask
  task automatic t_const;
    run(OP_L_K1, 8'h00, 16'h5a42);
    chk(acc, 16'h0042);
    run(OP_L_K2, 8'h00, 16'h4142);
    chk(acc, 16'h4142);
    run(OP_L_KBCD, 8'h00, 16'h0999);
    chk(acc, 16'h0999);
    run(OP_L_TC, 8'h2c, 16'h0000);
    chk(acc, 16'h00e8);
    run(OP_LC_TC, 8'h3f, 16'h0000);
    chk(acc, 16'h0289);
  endtask
  task automatic t_image;
    run(OP_L_K2, 8'h00, 16'h1234);
    run(OP_T_IW, 8'h04, 16'h0000);
    run(OP_L_IB, 8'h05, 16'h0000);
    chk(acc, 16'h0034);
    run(OP_L_IW, 8'h04, 16'h0000);
    chk(acc, 16'h1234);
    run(OP_T_QW, 8'h00, 16'h0000);
    chk({8'h00, out_b0}, 16'h0012);
    run(OP_L_QB, 8'h01, 16'h0000);
    chk(acc, 16'h0034);
    run(OP_L_QW, 8'h00, 16'h0000);
    chk(acc, 16'h1234);
  endtask
  task automatic t_flag;
    run(OP_L_K2, 8'h00, 16'habcd);
    run(OP_T_FW, 8'h10, 16'h0000);
    run(OP_L_FW, 8'h10, 16'h0000);
    chk(acc, 16'habcd);
    run(OP_L_FY, 8'h11, 16'h0000);
    chk(acc, 16'h00cd);
    run(OP_T_FY, 8'h20, 16'h0000);
    run(OP_L_FW, 8'h1f, 16'h0000);
    chk(acc, 16'h00cd);
  endtask
  task automatic t_periph;
    run(OP_L_K1, 8'h00, 16'h003c);
    run(OP_T_IB, 8'h03, 16'h0000);
    run(OP_L_K2, 8'h00, 16'hffff);
    run(OP_L_PY, 8'h03, 16'h0000);
    chk(acc, 16'h003c);
    run(OP_L_PW, 8'h03, 16'h0000);
    chk(acc, 16'h3c12);
    run(OP_L_K1, 8'h00, 16'h007e);
    run(OP_T_PY, 8'h00, 16'h0000);
    chk({irq_b0, out_b0}, 16'h7e7e);
  endtask
  task automatic t_data;
    run(OP_L_K2, 8'h00, 16'hffff);
    run(plte_op_e'(5'h1f), 8'h00, 16'h0000);
    chk(acc, 16'hffff);
    run(OP_L_DHB, 8'h05, 16'h0000);
    chk(acc, 16'h0000);
    run(OP_L_K2, 8'h00, 16'hffff);
    run(OP_L_DLB, 8'h05, 16'h0000);
    chk(acc, 16'h0000);
    run(OP_L_K2, 8'h00, 16'hffff);
    run(OP_L_DW, 8'h05, 16'h0000);
    chk(acc, 16'h0000);
  endtask
  initial begin
    sys_rst_i = 1'b1;
    instr_valid_i = 1'b0;
    logic_result_bit_i = 1'b0;
    instr_i = '0;
    fail_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_bits();
    t_const();
    t_image();
    t_flag();
    t_periph();
    t_data();
    end_of_test();
  end
endmodule
`default_nettype wire
